// ### hdl/ccvp_top.sv
// character-cell video pipeline: shared memories, decode, serialiser
// Behaviour
// - glyph store is 4096 words of 9 bits on data 8..0
// - 256 characters of up to 16 rows, picked by 8-bit code
// - refresh glyph address is code above four-bit row count
// - bus sees rows of character N at word offsets N0..NF
// - dot row shifts out MSB first, bit 8 leftmost
// - 8-bit strap feeds glyph bit 0 onto bit 8
// - dual-ported glyph store, same timing as display memory
// - attribute bits act when stored zero, save mono bits 10 and 8 passed straight to red and blue
// - colour codes 13..11 foreground, 10..8 background, 000 white
// - bit 15 clear makes the cell blink
// - bit 14 clear underlines the cell
// - control port sets border, cursor mode, stretch or modulation
// - straps pick mono or colour and 6..10 dot cell
// - ten-dot cell repeats first pixel as last
// - ROM glyph store gives only 8 dots per row
// - alternate serialiser swaps 7-dot width for 6
// - decoder answers FC0000 to FCA05F
// - display at FC0000-FC7FFF, glyphs at FC8000-FC9FFF
// - selects for peripherals at FCA000, timing FCA040, serial FCA050
// - low byte is character code, high byte attributes
// - two memory slots per character, refresh and bus
// - only data address modifiers reach the memories
`timescale 1ns/1ps
`default_nettype none

module ccvp_top (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   bus_req,
  input  wire ccvp_pkg::ccvp_busreq_s bus_cmd,
  output logic                        bus_ack,
  output logic [15:0]                 bus_rdata,
  output logic                        sel_parallel_timer_peripheral,
  output logic                        sel_video_timing_controller,
  output logic                        sel_dual_serial_controller,
  input  wire ccvp_pkg::ccvp_ctrl_s   ctrl,
  input  wire ccvp_pkg::ccvp_strap_s  strap,
  input  wire ccvp_pkg::ccvp_timing_s tim,
  output logic                        char_clk,
  output var ccvp_pkg::ccvp_rgb_s     pix_rgb,
  output logic                        pix_hilite
);
  import ccvp_pkg::*;

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic [15:0] disp_mem [DISP_WORDS];
  logic [8:0]  gly_mem  [GLY_WORDS];

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  logic [23:0] off;
  logic        in_blk;
  logic        am_ok;
  logic        hit_disp;
  logic        hit_gly;
  logic        mem_hit;
  logic [13:0] disp_wa;
  logic [11:0] gly_wa;

  assign off      = bus_cmd.addr - BASE_ADDR;
  assign in_blk   = (bus_cmd.addr >= BASE_ADDR) && (off <= BLK_HI);
  assign am_ok    = (bus_cmd.am == AM_STD_DATA)
                 || (bus_cmd.am == AM_SUP_DATA);
  assign hit_disp = in_blk && (off <= DISP_HI);
  assign hit_gly  = in_blk && (off >= GLY_LO) && (off <= GLY_HI);
  assign mem_hit  = bus_req && am_ok && (hit_disp || hit_gly);
  assign disp_wa  = off[14:1];
  assign gly_wa   = off[12:1];

  assign sel_parallel_timer_peripheral = bus_req && in_blk
                  && (off >= PTP_LO) && (off <= PTP_HI);
  assign sel_video_timing_controller = bus_req && in_blk
                  && (off >= VTC_LO) && (off <= VTC_HI);
  assign sel_dual_serial_controller = bus_req && in_blk
                  && (off >= DSC_LO) && (off <= BLK_HI);

  // ------------------------------------------------------------------
  // cell width and dot timing
  // ------------------------------------------------------------------
  logic [3:0] width;
  logic       half_mode;
  logic       half_r;
  logic       step;
  logic [3:0] dot_r;
  logic       bound;
  logic       slot_bus;
  logic       char_clk_r;

  always_comb begin
    unique case (strap.width)
      2'h0: width = strap.alt_six ? CW6 : CW7;
      2'h1: width = CW8;
      2'h2: width = CW9;
      2'h3: width = CW10;
    endcase
  end

  assign half_mode = (ctrl.dot_mode == DOTM_HALF)
                  || (ctrl.dot_mode == DOTM_MOD);
  assign step      = !half_mode || half_r;
  assign bound     = step && (dot_r == width - 4'h1);
  assign slot_bus  = step && (dot_r == BUS_DOT);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      half_r <= 1'b0;
    end else begin
      half_r <= half_mode ? ~half_r : 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dot_r <= 4'h0;
    end else if (step) begin
      dot_r <= bound ? 4'h0 : dot_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      char_clk_r <= 1'b0;
    end else begin
      char_clk_r <= dot_r < {1'b0, width[3:1]};
    end
  end

  assign char_clk = char_clk_r;

  // ------------------------------------------------------------------
  // bus slot
  // ------------------------------------------------------------------
  logic        ack_r;
  logic [15:0] rdata_r;
  logic        do_bus;

  assign do_bus = slot_bus && mem_hit && !ack_r;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ack_r   <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ack_r <= do_bus;
      if (do_bus && !bus_cmd.we) begin
        rdata_r <= hit_disp ? disp_mem[disp_wa]
                            : {7'h00, gly_mem[gly_wa]};
      end
    end
  end

  assign bus_ack   = ack_r;
  assign bus_rdata = rdata_r;

  always_ff @(posedge clk_sys) begin
    if (do_bus && bus_cmd.we && hit_disp) begin
      if (bus_cmd.be[1]) begin
        disp_mem[disp_wa][15:8] <= bus_cmd.wdata[15:8];
      end
      if (bus_cmd.be[0]) begin
        disp_mem[disp_wa][7:0] <= bus_cmd.wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_bus && bus_cmd.we && hit_gly) begin
      if (bus_cmd.be[1]) begin
        gly_mem[gly_wa][8] <= bus_cmd.wdata[8];
      end
      if (bus_cmd.be[0]) begin
        gly_mem[gly_wa][7:0] <= bus_cmd.wdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // refresh fetch pipeline
  // ------------------------------------------------------------------
  logic [15:0]  disp_r;
  logic [15:0]  cell_r;
  logic [8:0]   glyph_r;
  ccvp_timing_s tim1_r;
  ccvp_timing_s tim2_r;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      disp_r <= DISP_RST;
      cell_r <= DISP_RST;
      tim1_r <= '0;
      tim2_r <= '0;
    end else if (bound) begin
      disp_r <= disp_mem[tim.refresh_addr];
      cell_r <= disp_r;
      tim1_r <= tim;
      tim2_r <= tim1_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      glyph_r <= GLY_RST;
    end else if (step && dot_r == GLY_DOT) begin
      glyph_r <= gly_mem[{disp_r[7:0], tim1_r.row_scan}];
    end
  end

  // ------------------------------------------------------------------
  // dot row forming and shifting
  // ------------------------------------------------------------------
  logic [8:0] g9;
  logic [9:0] pattern;
  logic [9:0] shreg_r;
  logic       prev_r;
  logic       prom_tie;

  assign prom_tie = strap.prom_width_strap_a && strap.prom_width_strap_b;

  always_comb begin
    g9 = glyph_r;
    if (prom_tie) begin
      g9[8] = glyph_r[0];
    end else if (strap.rom_fitted) begin
      g9[8] = 1'b0;
    end
    pattern = (width == CW10) ? {g9, g9[8]} : {g9, 1'b0};
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      shreg_r <= SHIFT_RST;
    end else if (bound) begin
      shreg_r <= pattern;
    end else if (step) begin
      shreg_r <= {shreg_r[8:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prev_r <= 1'b0;
    end else if (step) begin
      prev_r <= shreg_r[9];
    end
  end

  // ------------------------------------------------------------------
  // attributes and colour
  // ------------------------------------------------------------------
  logic      dot;
  logic      blink_on;
  logic      ul_on;
  logic      on;
  ccvp_rgb_s rgb_nxt;
  ccvp_rgb_s pix_r;
  logic      hil_nxt;
  logic      hil_r;

  always_comb begin
    dot = shreg_r[9];
    if (ctrl.dot_mode == DOTM_STRETCH) begin
      dot = shreg_r[9] || prev_r;
    end
    blink_on = !cell_r[15] && tim2_r.blink;
    ul_on    = !cell_r[14] && tim2_r.ul_row;
    on       = (dot && !blink_on) || ul_on;
    if (tim2_r.cursor) begin
      on = ctrl.cursor_mode ? !on : (on || tim2_r.ul_row);
    end
    if (!strap.colour && !cell_r[9]) begin
      on = !on;
    end
    if (!strap.colour && !cell_r[11]) begin
      on = 1'b0;
    end
    if (ctrl.dot_mode == DOTM_MOD && half_r) begin
      on = 1'b0;
    end
    hil_nxt = 1'b0;
    if (strap.colour) begin
      rgb_nxt = on ? ~cell_r[13:11] : ~cell_r[10:8];
    end else begin
      rgb_nxt = '{r: cell_r[10], g: on, b: cell_r[8]};
      hil_nxt = on && !cell_r[13];
    end
    if (!tim2_r.active) begin
      rgb_nxt = ctrl.border;
      hil_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pix_r <= '0;
      hil_r <= 1'b0;
    end else begin
      pix_r <= rgb_nxt;
      hil_r <= hil_nxt;
    end
  end

  assign pix_rgb    = pix_r;
  assign pix_hilite = hil_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_ack_in_slot: assert property (bus_ack |-> $past(slot_bus))
    else $error("acknowledge outside bus slot");
  chk_ack_latency: assert property ($rose(mem_hit) |-> ##[1:22] bus_ack)
    else $error("bus access not served within two characters");
  chk_ack_data_am: assert property (bus_ack |-> $past(am_ok && mem_hit))
    else $error("acknowledge for rejected access");
  chk_glyph_upper: assert property (
      bus_ack && $past(hit_gly && !bus_cmd.we) |-> bus_rdata[15:9] == 7'h00)
    else $error("glyph read shows upper bits");
  chk_border_blank: assert property (
      !$past(tim2_r.active) |-> pix_rgb == $past(ctrl.border))
    else $error("border not shown outside display");
  chk_load_msb: assert property (
      bound && tim1_r.active && !prom_tie && !strap.rom_fitted
      |=> shreg_r[9] == $past(glyph_r[8]))
    else $error("row not loaded msb first");
  chk_shift_order: assert property (
      step && !bound && tim2_r.active |=> shreg_r[9] == $past(shreg_r[8]))
    else $error("dot row not shifted msb first");
  chk_ten_edges: assert property (
      bound && width == CW10 && tim1_r.active |=> shreg_r[9] == shreg_r[0])
    else $error("ten dot cell edges differ");
  chk_prom_tie: assert property (
      bound && prom_tie && tim1_r.active |=> shreg_r[9] == $past(glyph_r[0]))
    else $error("bit 0 not fed to bit 8");
  chk_fg_colour: assert property (
      strap.colour && tim2_r.active && on |=> pix_rgb == ~$past(cell_r[13:11]))
    else $error("foreground colour wrong");

  cov_bus_write: cover property (bus_ack && $past(bus_cmd.we && hit_gly));
  cov_ten_dot:   cover property (bound && width == CW10);
  cov_blink:     cover property (blink_on && tim2_r.active);
  cov_half_rate: cover property (bound && half_mode);

endmodule : ccvp_top

`default_nettype wire

// ### hdl/ccvp_pkg.sv
// constants and carriers for the character-cell video pipeline
package ccvp_pkg;

  // ------------------------------------------------------------------
  // address map
  // ------------------------------------------------------------------
  localparam logic [23:0] BASE_ADDR = 24'hFC0000;
  localparam logic [23:0] DISP_HI   = 24'h007FFF;
  localparam logic [23:0] GLY_LO    = 24'h008000;
  localparam logic [23:0] GLY_HI    = 24'h009FFF;
  localparam logic [23:0] PTP_LO    = 24'h00A000;
  localparam logic [23:0] PTP_HI    = 24'h00A03F;
  localparam logic [23:0] VTC_LO    = 24'h00A040;
  localparam logic [23:0] VTC_HI    = 24'h00A04F;
  localparam logic [23:0] DSC_LO    = 24'h00A050;
  localparam logic [23:0] BLK_HI    = 24'h00A05F;

  // ------------------------------------------------------------------
  // address modifiers accepted for memory
  // ------------------------------------------------------------------
  localparam logic [5:0] AM_STD_DATA = 6'h39;
  localparam logic [5:0] AM_SUP_DATA = 6'h3D;

  // ------------------------------------------------------------------
  // memory sizes, slots, reset values
  // ------------------------------------------------------------------
  localparam int          DISP_WORDS = 16384;
  localparam int          GLY_WORDS  = 4096;
  localparam logic [3:0]  GLY_DOT    = 4'h1;
  localparam logic [3:0]  BUS_DOT    = 4'h3;
  localparam logic [15:0] DISP_RST   = 16'hFFFF;
  localparam logic [9:0]  SHIFT_RST  = 10'h000;
  localparam logic [8:0]  GLY_RST    = 9'h000;

  // ------------------------------------------------------------------
  // cell widths and dot modes
  // ------------------------------------------------------------------
  localparam logic [3:0] CW6  = 4'h6;
  localparam logic [3:0] CW7  = 4'h7;
  localparam logic [3:0] CW8  = 4'h8;
  localparam logic [3:0] CW9  = 4'h9;
  localparam logic [3:0] CW10 = 4'hA;

  typedef enum logic [2:0] {
    DOTM_FULL    = 3'h0,
    DOTM_STRETCH = 3'h1,
    DOTM_HALF    = 3'h2,
    DOTM_MOD     = 3'h6
  } ccvp_dotm_e;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        we;
    logic [5:0]  am;
    logic [23:0] addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } ccvp_busreq_s;

  typedef struct packed {
    logic [2:0] border;
    logic       cursor_mode;
    logic [2:0] dot_mode;
  } ccvp_ctrl_s;

  typedef struct packed {
    logic       colour;
    logic [1:0] width;
    logic       alt_six;
    logic       prom_width_strap_a;
    logic       prom_width_strap_b;
    logic       rom_fitted;
  } ccvp_strap_s;

  typedef struct packed {
    logic [13:0] refresh_addr;
    logic [3:0]  row_scan;
    logic        active;
    logic        cursor;
    logic        blink;
    logic        ul_row;
  } ccvp_timing_s;

  typedef struct packed {
    logic r;
    logic g;
    logic b;
  } ccvp_rgb_s;

endpackage : ccvp_pkg

// ### testbench/ccvp_bus_master.sv
// bus master model issuing word and byte data accesses
`timescale 1ns/1ps
`default_nettype none
module ccvp_bus_master (
  input  wire logic              clk_sys,
  output logic                   bus_req,
  output var ccvp_pkg::ccvp_busreq_s bus_cmd,
  input  wire logic              bus_ack,
  input  wire logic [15:0]       bus_rdata
);
  import ccvp_pkg::*;
  initial begin
    bus_req = 1'b0;
    bus_cmd = '0;
  end
  // ------------------------------------------------------------------
  // one access, held until ack or 60 edges
  // ------------------------------------------------------------------
  task automatic access(input logic we, input logic [5:0] am, input logic [23:0] a,
                        input logic [1:0] be, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
    ok = 1'b0;
    rd = 16'h0000;
    @(posedge clk_sys);
    #1;
    bus_req = 1'b1;
    bus_cmd = '{we, am, a, be, wd};
    for (int n = 0; n < 60 && !ok; n++) begin
      @(posedge clk_sys);
      if (bus_ack === 1'b1) begin
        rd = bus_rdata;
        ok = 1'b1;
      end
    end
    #1;
    bus_req = 1'b0;
    bus_cmd = ~bus_cmd;
  endtask : access
endmodule : ccvp_bus_master
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the character-cell video pipeline
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccvp_pkg::*;
  logic         clk_sys, rstn, bus_req, bus_ack, char_clk, pix_hilite, ok;
  logic         s_ptp, s_vtc, s_dsc, hit;
  logic [15:0]  bus_rdata, rd, d, w;
  logic [8:0]   g;
  logic [3:0]   smp [40];
  ccvp_busreq_s bus_cmd;
  ccvp_ctrl_s   ctrl;
  ccvp_strap_s  strap;
  ccvp_timing_s tim;
  ccvp_rgb_s    pix_rgb;
  int           n_mismatch, cmp_count, cw, sp, nh;

  ccvp_top u_ccvp_top (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req), .bus_cmd(bus_cmd),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .sel_parallel_timer_peripheral(s_ptp),
    .sel_video_timing_controller(s_vtc), .sel_dual_serial_controller(s_dsc), .ctrl(ctrl),
    .strap(strap), .tim(tim), .char_clk(char_clk), .pix_rgb(pix_rgb), .pix_hilite(pix_hilite));
  ccvp_bus_master u_ccvp_bus_master (.clk_sys(clk_sys), .bus_req(bus_req), .bus_cmd(bus_cmd),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ------------------------------------------------------------------
  // checks and bus helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic we, input logic [5:0] am, input logic [23:0] a,
                     input logic [1:0] be, input logic [15:0] wd);
    u_ccvp_bus_master.access(we, am, a, be, wd, rd, ok);
  endtask : acc
  task automatic wr(input logic [23:0] a, input logic [1:0] be, input logic [15:0] wd);
    acc(1'b1, AM_STD_DATA, a, be, wd);
    chk({15'h0, ok}, 16'h0001);
  endtask : wr
  task automatic rdc(input logic [23:0] a, input logic [15:0] exp);
    acc(1'b0, AM_SUP_DATA, a, 2'b11, 16'h0000);
    chk({15'h0, ok}, 16'h0001);
    chk(rd, exp);
  endtask : rdc
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // ------------------------------------------------------------------
  // expected pixel of dot i in a cell
  // ------------------------------------------------------------------
  function automatic logic [3:0] exp_px(input int i);
    logic [8:0] f;
    logic       b;
    f = {(strap.prom_width_strap_a & strap.prom_width_strap_b) ? g[0] :
         (strap.rom_fitted ? 1'b0 : g[8]), g[7:0]};
    b = (i == 9) ? f[8] : f[8-i];
    if (!w[14] && tim.ul_row) b = 1'b1;
    if (!w[15] && tim.blink) b = 1'b0;
    if (!strap.colour) begin
      b = (b ^ !w[9]) & w[11];
      return {w[10], b, w[8], b & !w[13]};
    end
    return {b ? ~w[13:11] : ~w[10:8], 1'b0};
  endfunction : exp_px
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(98186));
    rstn = 1'b0;
    ctrl = '0;
    strap = '0;
    tim = '0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({bus_ack, char_clk, pix_rgb, pix_hilite}, 16'h0000);
    chk(bus_rdata, 16'h0000);
    rstn = 1'b1;
    for (int k = 0; k < 6; k++) begin
      w = 16'($urandom());
      d = {2'b00, w[13:0]} << 1;
      wr(24'hFC0000 + 24'(d), 2'b11, 16'hA55A ^ w);
      wr(24'hFC0000 + 24'(d), k[0] ? 2'b10 : 2'b01, w);
      rdc(24'hFC0000 + 24'(d), k[0] ? {w[15:8], 8'h5A ^ w[7:0]} : {8'hA5 ^ w[15:8], w[7:0]});
    end
    wr(24'hFC9FFE, 2'b11, 16'hFFFF);
    rdc(24'hFC9FFE, 16'h01FF);
    wr(24'hFC8000, 2'b11, 16'h0100);
    wr(24'hFC8000, 2'b01, 16'h0000);
    rdc(24'hFC8000, 16'h0100);
    acc(1'b0, 6'h09, 24'hFC0000, 2'b11, 16'h0000);
    chk({15'h0, ok}, 16'h0000);
    acc(1'b0, AM_STD_DATA, 24'hFCA060, 2'b11, 16'h0000);
    chk({15'h0, ok}, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      fork
        acc(1'b0, AM_STD_DATA, k == 0 ? 24'hFCA000 : (k == 1 ? 24'hFCA040 : 24'hFCA050),
            2'b11, 16'h0000);
        begin
          repeat (3) @(posedge clk_sys);
          #1;
          chk({13'h0, s_ptp, s_vtc, s_dsc}, 16'h0004 >> k);
        end
      join
      chk({15'h0, ok}, 16'h0000);
    end
    for (int k = 0; k < 11; k++) begin
      g = {1'b1, 7'($urandom()), 1'b0};
      d = 16'($urandom());
      w = {k != 7, k != 8, d[13:11], d[13:11] ^ 3'h5, d[7:0]};
      wr(24'hFC8000 + {11'h0, w[7:0], d[11:8], 1'b0}, 2'b11, {7'h0, g});
      wr(24'hFC0000 + {9'h0, d[14:1], 1'b0}, 2'b11, w);
      @(posedge clk_sys);
      #1;
      ctrl = '{3'($urandom()), 1'($urandom()), k == 10 ? DOTM_HALF : DOTM_FULL};
      strap = '{k != 9, k < 4 ? 2'(k) : (k == 4 ? 2'd0 : 2'd2), k == 4, k == 5, k == 5, k == 6};
      tim = '{d[14:1], d[11:8], 1'b1, 1'b0, k == 7, k == 8};
      cw = (strap.width == 2'd0) ? (strap.alt_six ? 6 : 7) : 32'(strap.width) + 7;
      sp = (ctrl.dot_mode == DOTM_HALF) ? 2 : 1;
      nh = 0;
      repeat (50) @(posedge clk_sys);
      for (int i = 0; i < 40; i++) begin
        @(posedge clk_sys);
        #1;
        smp[i] = {pix_rgb, pix_hilite};
        if (i < cw * sp && char_clk === 1'b1) nh++;
      end
      chk(16'(nh), 16'(sp * (cw / 2)));
      hit = 1'b0;
      for (int o = 0; o < cw * sp; o++) begin
        ok = 1'b1;
        for (int i = 0; i < cw * sp; i++)
          if (smp[o+i] !== exp_px(i / sp)) ok = 1'b0;
        hit = hit | ok;
      end
      chk({12'h0, k[3:0]}, {12'h0, hit ? k[3:0] : 4'hF});
    end
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    results();
  end
endmodule : testbench
`default_nettype wire
